/* File: rtl/iobrk_params.svh */
`ifndef IOBRK_PARAMS_SVH
`define IOBRK_PARAMS_SVH

// Indices of the configuration registers behind the data port.
`define IOBRK_IDX_MASK_A 8'h80
`define IOBRK_IDX_MASK_B 8'h81
`define IOBRK_IDX_CAUSE_A 8'h82
`define IOBRK_IDX_CAUSE_B 8'h83
`define IOBRK_IDX_WIN2_HI 8'h84
`define IOBRK_IDX_WIN2_LO 8'h85
`define IOBRK_IDX_WIN1_HI 8'h86
`define IOBRK_IDX_WIN1_LO 8'h87

// Bit positions in enable B and cause B.
`define IOBRK_B_KBD_RD 7
`define IOBRK_B_KBD_WR 6
`define IOBRK_B_CMOS 5
`define IOBRK_B_DMA2 4
`define IOBRK_B_DMA1 3
`define IOBRK_B_INTC2 2
`define IOBRK_B_INTC1 1
`define IOBRK_B_TIMER 0

// Bit positions in enable A and cause A.
`define IOBRK_A_WIN2 6
`define IOBRK_A_WIN1 5
`define IOBRK_A_HDISK 4
`define IOBRK_A_FLOPPY 3
`define IOBRK_A_PRINTER 2
`define IOBRK_A_SERIAL2 1
`define IOBRK_A_SERIAL1 0

// Reset values.
`define IOBRK_MASK_RST 8'h00
`define IOBRK_CAUSE_RST 8'h00
`define IOBRK_WIN_RST 8'h00
`define IOBRK_RDATA_RST 8'h00

// Bits of enable A that software may change; bit 7 reads as zero.
`define IOBRK_MASK_A_USED 8'h7F

// Fixed I/O decodes, compared on address bits 9..0.
`define IOBRK_KBD_DATA 10'h060
`define IOBRK_KBD_PORTB 10'h061
`define IOBRK_KBD_CMD 10'h064
`define IOBRK_CMOS_IDX 10'h070
`define IOBRK_DMA2_LO 10'h0C0
`define IOBRK_DMA2_HI 10'h0DE
`define IOBRK_DMA1_LO 10'h000
`define IOBRK_DMA1_HI 10'h00F
`define IOBRK_INTC2_LO 10'h020
`define IOBRK_INTC2_HI 10'h021
`define IOBRK_INTC1_LO 10'h0A0
`define IOBRK_INTC1_HI 10'h0A1
`define IOBRK_TIMER_LO 10'h040
`define IOBRK_TIMER_HI 10'h043
`define IOBRK_HDISK_LO 10'h1F0
`define IOBRK_HDISK_HI 10'h1F7
`define IOBRK_HDISK_ALT 10'h3F6
`define IOBRK_FLOPPY_LO 10'h3F0
`define IOBRK_FLOPPY_HI 10'h3F5
`define IOBRK_PRINTER_LO 10'h378
`define IOBRK_PRINTER_HI 10'h37A
`define IOBRK_SERIAL2_LO 10'h2F8
`define IOBRK_SERIAL2_HI 10'h2FF
`define IOBRK_SERIAL1_LO 10'h3F8
`define IOBRK_SERIAL1_HI 10'h3FF

// Window size codes and the address bits each one compares.
`define IOBRK_SIZE_4 2'h0
`define IOBRK_SIZE_8 2'h1
`define IOBRK_SIZE_16 2'h2
`define IOBRK_SIZE_32 2'h3
`define IOBRK_CARE_4 16'hFFFC
`define IOBRK_CARE_8 16'hFFF8
`define IOBRK_CARE_16 16'hFFF0
`define IOBRK_CARE_32 16'hFFE0
`define IOBRK_CARE_TEN 16'h03FF

`endif

/* File: rtl/iobrk_pkg.sv */
package iobrk_pkg;

  // One configuration byte.
  typedef logic [7:0] iobrk_byte_t;

  // Complete state of the detector; entry 0 is window one, entry 1 window two.
  typedef struct packed {
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] cause_a;
    logic [7:0] cause_b;
    logic [1:0][7:0] win_hi;
    logic [1:0][7:0] win_lo;
    logic [7:0] rdata;
    logic irq_n;
    logic pending;
  } iobrk_state_t;

endpackage

/* File: rtl/iobrk_win_if.sv */
`timescale 1ns/1ns
// Carries one programmable window's setup and the bus address to its matcher.
interface iobrk_win_if;
  logic [7:0] base_hi;
  logic [7:0] base_lo;
  logic ten_bit;
  logic [15:0] addr;
  logic hit;
  modport owner (output base_hi, output base_lo, output ten_bit, output addr, input hit);
  modport match (input base_hi, input base_lo, input ten_bit, input addr, output hit);
endinterface

/* File: rtl/iobrk_window.sv */
`timescale 1ns/1ns
`include "iobrk_params.svh"
module iobrk_window (
  // Window setup and address in, match out.
  iobrk_win_if.match win
);
  import iobrk_pkg::*;

  logic [15:0] base;
  logic [15:0] care;

  // Base address bits 15..8 from the high byte, 7..2 from the low byte.
  always_comb begin
    base = {win.base_hi, win.base_lo[7:2], 2'b00};
    case (win.base_lo[1:0])
      `IOBRK_SIZE_4: care = `IOBRK_CARE_4;
      `IOBRK_SIZE_8: care = `IOBRK_CARE_8;
      `IOBRK_SIZE_16: care = `IOBRK_CARE_16;
      default: care = `IOBRK_CARE_32;
    endcase
    if (win.ten_bit) begin
      care = care & `IOBRK_CARE_TEN;
    end
  end

  // Bits below the window size and masked upper bits do not take part.
  assign win.hit = ((win.addr ^ base) & care) == 16'h0000;

endmodule

/* File: rtl/iobrk_top.sv */
`timescale 1ns/1ns
`include "iobrk_params.svh"
module iobrk_top (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Processor I/O cycle seen on the system bus.
  input wire logic io_valid_i,
  input wire logic io_write_i,
  input wire logic [15:0] io_addr_i,
  // Indexed configuration port.
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire iobrk_pkg::iobrk_byte_t cfg_index_i,
  input wire iobrk_pkg::iobrk_byte_t cfg_wdata_i,
  output iobrk_pkg::iobrk_byte_t cfg_rdata_o,
  // Control and mode bits held elsewhere in the controller.
  input wire logic break_enable_i,
  input wire logic mask_lock_i,
  input wire logic mgmt_active_i,
  input wire logic ten_bit_decode_sel_i,
  input wire logic [4:0] timer_status_i,
  // Interrupt request and summary flag.
  output logic mgmt_irq_n_o,
  output logic any_break_pending_o
);
  import iobrk_pkg::*;

  localparam iobrk_state_t ST_RST = '{
    mask_a: `IOBRK_MASK_RST,
    mask_b: `IOBRK_MASK_RST,
    cause_a: `IOBRK_CAUSE_RST,
    cause_b: `IOBRK_CAUSE_RST,
    win_hi: {`IOBRK_WIN_RST, `IOBRK_WIN_RST},
    win_lo: {`IOBRK_WIN_RST, `IOBRK_WIN_RST},
    rdata: `IOBRK_RDATA_RST,
    irq_n: 1'b1,
    pending: 1'b0
  };

  iobrk_state_t st_reg;
  iobrk_state_t st_next;

  logic [9:0] low_addr;
  logic upper_ok;
  logic [1:0] win_hit;
  logic is_read;
  logic is_write;
  logic hit_kbd;
  logic hit_cmos;
  logic hit_dma2;
  logic hit_dma1;
  logic hit_intc2;
  logic hit_intc1;
  logic hit_timer;
  logic hit_hdisk;
  logic hit_floppy;
  logic hit_printer;
  logic hit_serial2;
  logic hit_serial1;
  logic [7:0] raw_a;
  logic [7:0] raw_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic mask_wr_ok;
  logic rd_cause_a;
  logic rd_cause_b;
  logic [7:0] rd_value;

  // One matcher per programmable window, fed from the stored base bytes.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_win
      iobrk_win_if wif ();
      assign wif.base_hi = st_reg.win_hi[g];
      assign wif.base_lo = st_reg.win_lo[g];
      assign wif.ten_bit = ten_bit_decode_sel_i;
      assign wif.addr = io_addr_i;
      iobrk_window u_win (
        .win(wif.match)
      );
      assign win_hit[g] = wif.hit;
    end
  endgenerate

  // Fixed decodes see bits 9..0; in sixteen-bit mode the upper bits must be zero.
  assign low_addr = io_addr_i[9:0];
  assign upper_ok = ten_bit_decode_sel_i | (io_addr_i[15:10] == 6'h00);
  assign is_read = io_valid_i & ~io_write_i;
  assign is_write = io_valid_i & io_write_i;

  // Address range decodes for the hardwired device groups.
  always_comb begin
    hit_kbd = upper_ok & ((low_addr == `IOBRK_KBD_DATA) | (low_addr == `IOBRK_KBD_PORTB) |
                          (low_addr == `IOBRK_KBD_CMD));
    hit_cmos = upper_ok & (low_addr == `IOBRK_CMOS_IDX);
    hit_dma2 = upper_ok & (low_addr >= `IOBRK_DMA2_LO) & (low_addr <= `IOBRK_DMA2_HI) & ~low_addr[0];
    hit_dma1 = upper_ok & (low_addr >= `IOBRK_DMA1_LO) & (low_addr <= `IOBRK_DMA1_HI);
    hit_intc2 = upper_ok & ((low_addr == `IOBRK_INTC2_LO) | (low_addr == `IOBRK_INTC2_HI));
    hit_intc1 = upper_ok & ((low_addr == `IOBRK_INTC1_LO) | (low_addr == `IOBRK_INTC1_HI));
    hit_timer = upper_ok & (low_addr >= `IOBRK_TIMER_LO) & (low_addr <= `IOBRK_TIMER_HI);
    hit_hdisk = upper_ok & (((low_addr >= `IOBRK_HDISK_LO) & (low_addr <= `IOBRK_HDISK_HI)) |
                            (low_addr == `IOBRK_HDISK_ALT));
    hit_floppy = upper_ok & (low_addr >= `IOBRK_FLOPPY_LO) & (low_addr <= `IOBRK_FLOPPY_HI);
    hit_printer = upper_ok & (low_addr >= `IOBRK_PRINTER_LO) & (low_addr <= `IOBRK_PRINTER_HI);
    hit_serial2 = upper_ok & (low_addr >= `IOBRK_SERIAL2_LO) & (low_addr <= `IOBRK_SERIAL2_HI);
    hit_serial1 = upper_ok & (low_addr >= `IOBRK_SERIAL1_LO) & (low_addr <= `IOBRK_SERIAL1_HI);
  end

  // Raw causes of the current cycle, split by register; only the B causes are qualified by direction.
  always_comb begin
    raw_b = 8'h00;
    raw_b[`IOBRK_B_KBD_RD] = is_read & hit_kbd;
    raw_b[`IOBRK_B_KBD_WR] = is_write & hit_kbd;
    raw_b[`IOBRK_B_CMOS] = is_write & hit_cmos;
    raw_b[`IOBRK_B_DMA2] = is_write & hit_dma2;
    raw_b[`IOBRK_B_DMA1] = is_write & hit_dma1;
    raw_b[`IOBRK_B_INTC2] = is_write & hit_intc2;
    raw_b[`IOBRK_B_INTC1] = is_write & hit_intc1;
    raw_b[`IOBRK_B_TIMER] = is_write & hit_timer;
    raw_a = 8'h00;
    raw_a[`IOBRK_A_WIN2] = io_valid_i & win_hit[1];
    raw_a[`IOBRK_A_WIN1] = io_valid_i & win_hit[0];
    raw_a[`IOBRK_A_HDISK] = io_valid_i & hit_hdisk;
    raw_a[`IOBRK_A_FLOPPY] = io_valid_i & hit_floppy;
    raw_a[`IOBRK_A_PRINTER] = io_valid_i & hit_printer;
    raw_a[`IOBRK_A_SERIAL2] = io_valid_i & hit_serial2;
    raw_a[`IOBRK_A_SERIAL1] = io_valid_i & hit_serial1;
  end

  // Only enabled breaks count, and none at all while the master enable is off.
  // Decodes are independent; the hard disk alternate address 3F6 lies outside the floppy range and raises only the hard disk bit.
  assign set_a = raw_a & st_reg.mask_a & {8{break_enable_i}};
  assign set_b = raw_b & st_reg.mask_b & {8{break_enable_i}};

  // Enable registers are frozen outside management mode while locked.
  assign mask_wr_ok = mgmt_active_i | ~mask_lock_i;

  // Read strobes that clear the cause registers.
  assign rd_cause_a = cfg_rd_i & (cfg_index_i == `IOBRK_IDX_CAUSE_A);
  assign rd_cause_b = cfg_rd_i & (cfg_index_i == `IOBRK_IDX_CAUSE_B);

  // Read multiplexer; unknown indices read as zero.
  always_comb begin
    if (cfg_index_i == `IOBRK_IDX_MASK_A) begin
      rd_value = st_reg.mask_a;
    end else if (cfg_index_i == `IOBRK_IDX_MASK_B) begin
      rd_value = st_reg.mask_b;
    end else if (cfg_index_i == `IOBRK_IDX_CAUSE_A) begin
      rd_value = st_reg.cause_a;
    end else if (cfg_index_i == `IOBRK_IDX_CAUSE_B) begin
      rd_value = st_reg.cause_b;
    end else if (cfg_index_i == `IOBRK_IDX_WIN2_HI) begin
      rd_value = st_reg.win_hi[1];
    end else if (cfg_index_i == `IOBRK_IDX_WIN2_LO) begin
      rd_value = st_reg.win_lo[1];
    end else if (cfg_index_i == `IOBRK_IDX_WIN1_HI) begin
      rd_value = st_reg.win_hi[0];
    end else if (cfg_index_i == `IOBRK_IDX_WIN1_LO) begin
      rd_value = st_reg.win_lo[0];
    end else begin
      rd_value = 8'h00;
    end
  end

  // Next state: configuration writes, read capture, cause update and request.
  always_comb begin
    st_next = st_reg;
    if (cfg_wr_i) begin
      if (cfg_index_i == `IOBRK_IDX_MASK_A) begin
        if (mask_wr_ok) begin
          st_next.mask_a = cfg_wdata_i & `IOBRK_MASK_A_USED;
        end
      end else if (cfg_index_i == `IOBRK_IDX_MASK_B) begin
        if (mask_wr_ok) begin
          st_next.mask_b = cfg_wdata_i;
        end
      end else if (cfg_index_i == `IOBRK_IDX_WIN2_HI) begin
        st_next.win_hi[1] = cfg_wdata_i;
      end else if (cfg_index_i == `IOBRK_IDX_WIN2_LO) begin
        st_next.win_lo[1] = cfg_wdata_i;
      end else if (cfg_index_i == `IOBRK_IDX_WIN1_HI) begin
        st_next.win_hi[0] = cfg_wdata_i;
      end else if (cfg_index_i == `IOBRK_IDX_WIN1_LO) begin
        st_next.win_lo[0] = cfg_wdata_i;
      end
    end
    if (cfg_rd_i) begin
      st_next.rdata = rd_value;
    end
    // A read clears the register, but a cause arriving in that cycle survives.
    st_next.cause_a = (rd_cause_a ? 8'h00 : st_reg.cause_a) | set_a;
    st_next.cause_b = (rd_cause_b ? 8'h00 : st_reg.cause_b) | set_b;
    // Low for one cycle after any cycle that records a new cause.
    st_next.irq_n = ~((|set_a) | (|set_b));
    // Summary drops only when both cause registers and all timer flags are clear.
    st_next.pending = (|st_next.cause_a) | (|st_next.cause_b) | (|timer_status_i);
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register.
  assign cfg_rdata_o = st_reg.rdata;
  assign mgmt_irq_n_o = st_reg.irq_n;
  assign any_break_pending_o = st_reg.pending;

endmodule

/* File: verif/iobrk_checker.sv */
`timescale 1ns/1ns
module iobrk_checker (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Bus cycle.
  input wire logic io_valid_i,
  input wire logic io_write_i,
  input wire logic [15:0] io_addr_i,
  // Configuration port.
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire iobrk_pkg::iobrk_byte_t cfg_index_i,
  input wire iobrk_pkg::iobrk_byte_t cfg_wdata_i,
  input wire iobrk_pkg::iobrk_byte_t cfg_rdata_o,
  // Mode inputs.
  input wire logic break_enable_i,
  input wire logic mask_lock_i,
  input wire logic mgmt_active_i,
  input wire logic ten_bit_decode_sel_i,
  input wire logic [4:0] timer_status_i,
  // Outputs under watch.
  input wire logic mgmt_irq_n_o,
  input wire logic any_break_pending_o
);
  import iobrk_pkg::*;
  // Every check runs on the system clock and sleeps during reset.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // A read of cause B with no bus cycle alongside.
  sequence s_read_b;
    cfg_rd_i && cfg_index_i == 8'h83 && !io_valid_i;
  endsequence
  a_master_off_quiet: assert property (!break_enable_i |=> mgmt_irq_n_o)
    else $error("irq with master enable off");
  a_idle_no_irq: assert property (!io_valid_i |=> mgmt_irq_n_o)
    else $error("irq without a bus cycle");
  a_irq_sets_flag: assert property (!mgmt_irq_n_o |-> any_break_pending_o)
    else $error("irq without summary flag");
  a_timer_sets_flag: assert property (timer_status_i != 5'h00 |=> any_break_pending_o)
    else $error("timer flag not summarised");
  a_unmapped_reads_zero: assert property (cfg_rd_i && cfg_index_i == 8'h90 |=> cfg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data moved without a read");
  a_cause_read_clears: assert property (s_read_b ##1 !io_valid_i ##1 s_read_b |=> cfg_rdata_o == 8'h00)
    else $error("cause not cleared by read");
  a_no_decode_quiet: assert property (io_valid_i && io_addr_i == 16'h0150 |=> mgmt_irq_n_o)
    else $error("irq on undecoded address");
endmodule
bind iobrk_top iobrk_checker chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .io_valid_i(io_valid_i),
  .io_write_i(io_write_i), .io_addr_i(io_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
  .cfg_index_i(cfg_index_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
  .break_enable_i(break_enable_i), .mask_lock_i(mask_lock_i), .mgmt_active_i(mgmt_active_i),
  .ten_bit_decode_sel_i(ten_bit_decode_sel_i), .timer_status_i(timer_status_i),
  .mgmt_irq_n_o(mgmt_irq_n_o), .any_break_pending_o(any_break_pending_o));

/* File: verif/iobrk_host_model.sv */
`timescale 1ns/1ns
module iobrk_host_model (
  // Clock.
  input wire logic mclk_i,
  // Bus cycle out.
  output logic io_valid_o,
  output logic io_write_o,
  output logic [15:0] io_addr_o
);
  // The bus is idle at time zero.
  initial begin
    io_valid_o = 1'b0;
    io_write_o = 1'b0;
    io_addr_o = 16'hFFFF;
  end
  // One cycle after an idle gap; released lines show the inverse so stale values never match.
  task automatic cyc(input logic w, input logic [15:0] a, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    io_valid_o <= 1'b1;
    io_write_o <= w;
    io_addr_o <= a;
    @(posedge mclk_i);
    io_valid_o <= 1'b0;
    io_write_o <= ~w;
    io_addr_o <= ~a;
  endtask
endmodule

/* File: verif/iobrk_tb_top.sv */
`timescale 1ns/1ns
module iobrk_tb_top;
  import iobrk_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic io_valid, io_write, irq_n, pending;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, brk_en = 1'b1, lock = 1'b0, active = 1'b0, ten = 1'b0;
  logic [15:0] io_addr;
  logic [4:0] tmr = 5'h00;
  iobrk_byte_t cfg_idx = 8'h00, cfg_wd = 8'h00, cfg_rdata, d;
  int failures = 0, checks = 0;
  // System clock at 10 MHz.
  always #50 mclk_i = ~mclk_i;
  iobrk_host_model host (.mclk_i(mclk_i), .io_valid_o(io_valid), .io_write_o(io_write), .io_addr_o(io_addr));
  iobrk_top uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .io_valid_i(io_valid), .io_write_i(io_write),
    .io_addr_i(io_addr), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_index_i(cfg_idx), .cfg_wdata_i(cfg_wd),
    .cfg_rdata_o(cfg_rdata), .break_enable_i(brk_en), .mask_lock_i(lock), .mgmt_active_i(active),
    .ten_bit_decode_sel_i(ten), .timer_status_i(tmr), .mgmt_irq_n_o(irq_n), .any_break_pending_o(pending));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input iobrk_byte_t i, input iobrk_byte_t v);
    @(posedge mclk_i);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_wd <= v;
    @(posedge mclk_i);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input iobrk_byte_t i);
    @(posedge mclk_i);
    cfg_rd <= 1'b1;
    cfg_idx <= i;
    @(posedge mclk_i);
    cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask
  // Each entry: cause A select, write, address, expected cause bits.
  task automatic run(input logic [25:0] t[$]);
    foreach (t[k]) begin
      host.cyc(t[k][24], t[k][23:8], k % 3);
      #1 chk("irq_n", {7'h00, irq_n}, {7'h00, t[k][7:0] == 8'h00});
      chk("pending", {7'h00, pending}, {7'h00, t[k][7:0] != 8'h00});
      rd(t[k][25] ? 8'h82 : 8'h83);
      chk("cause", d, t[k][7:0]);
    end
  endtask
  task automatic t_reset();
    rd(8'h81);
    chk("enable_b", d, 8'h00);
    rd(8'h83);
    chk("cause_b", d, 8'h00);
    rd(8'h90);
    chk("unmapped", d, 8'h00);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    chk("pending", {7'h00, pending}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_decode();
    wr(8'h80, 8'h1F);
    wr(8'h81, 8'hFF);
    run('{26'h0006080, 26'h1006140, 26'h1006440, 26'h0007000, 26'h1007020, 26'h1047000, 26'h100C010,
      26'h100DE10, 26'h100DD00, 26'h1000F08, 26'h1001000, 26'h1002104, 26'h100A002, 26'h1004301,
      26'h1004400, 26'h0004000, 26'h301F010, 26'h201F710, 26'h201F800, 26'h203F008, 26'h303F508,
      26'h2037804, 26'h2037A04, 26'h2037B00, 26'h202F802, 26'h202FF02, 26'h203F801, 26'h303FF01,
      26'h3015000, 26'h303F610});
    $display("test decode done");
  endtask
  task automatic t_window();
    wr(8'h80, 8'h60);
    wr(8'h84, 8'h05);
    wr(8'h85, 8'h42);
    wr(8'h86, 8'h02);
    wr(8'h87, 8'h00);
    rd(8'h84);
    chk("win_hi", d, 8'h05);
    run('{26'h2054F40, 26'h2055000, 26'h2054040, 26'h2020320, 26'h2020400});
    wr(8'h87, 8'h01);
    run('{26'h2020720, 26'h2020800});
    wr(8'h84, 8'hFD);
    wr(8'h85, 8'h83);
    run('{26'h2FD9F40, 26'h2019F00});
    @(posedge mclk_i);
    ten <= 1'b1;
    run('{26'h2019F40, 26'h2FD9F40});
    ten <= 1'b0;
    $display("test window done");
  endtask
  task automatic t_lock();
    @(posedge mclk_i);
    lock <= 1'b1;
    wr(8'h81, 8'h00);
    rd(8'h81);
    chk("enable_b", d, 8'hFF);
    active <= 1'b1;
    wr(8'h81, 8'h0F);
    rd(8'h81);
    chk("enable_b", d, 8'h0F);
    lock <= 1'b0;
    active <= 1'b0;
    $display("test lock done");
  endtask
  task automatic t_master();
    @(posedge mclk_i);
    brk_en <= 1'b0;
    run('{26'h1004000});
    brk_en <= 1'b1;
    run('{26'h1006000, 26'h1004001});
    $display("test master done");
  endtask
  task automatic t_pending();
    host.cyc(1'b1, 16'h0021, 1);
    #1 chk("pending", {7'h00, pending}, 8'h01);
    rd(8'h83);
    chk("cause_b", d, 8'h04);
    rd(8'h83);
    chk("cause_b", d, 8'h00);
    rd(8'h82);
    @(posedge mclk_i);
    #1 chk("pending", {7'h00, pending}, 8'h00);
    tmr <= 5'h10;
    repeat (2) @(posedge mclk_i);
    #1 chk("pending", {7'h00, pending}, 8'h01);
    tmr <= 5'h00;
    repeat (2) @(posedge mclk_i);
    #1 chk("pending", {7'h00, pending}, 8'h00);
    $display("test pending done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_decode();
    t_window();
    t_lock();
    t_master();
    t_pending();
    print_verdict();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #(5000 * 100);
    failures++;
    print_verdict();
  end
endmodule
